// >>> dv/servo_motion_setpoint_registers_tb.sv
// Self-checking bench for the setpoint register group.
// Assumes a short sample period of 20 clocks and a 10 MHz clock.
module servo_motion_setpoint_registers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, run = 0, down = 0, zdone = 0;
  logic        [7:0]  addr_i = 8'h00;
  logic        [31:0] wdata_i = 32'h0, zturn = 32'h0, zpos = 32'h0, rdata_o, load;
  logic signed [31:0] vcmd;
  logic signed [10:0] tcmd;
  logic               step, dir, enable;
  int                 num_errors = 0, num_checks = 0, cycles = 0;

  always #50 clk_i = ~clk_i;
  smsr_enc_model enc (.clk_i(clk_i), .run_i(run), .down_i(down), .step_o(step), .dir_o(dir));
  smsr_registers #(.SAMPLE_CYCLES(20)) dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .enc_step_i(step),
    .enc_dir_i(dir), .zero_done_i(zdone), .zero_single_turn_i(zturn),
    .zero_position_i(zpos), .drive_enable_o(enable), .velocity_command_o(vcmd),
    .torque_command_o(tcmd), .load_inertia_ratio_o(load));
  ////////////////////////////////////////
  // Compare, bus cycles and the closing report
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
  endtask
  // Waits past a possible sample cycle before reading all three positions
  task automatic pos3(logic [31:0] a, logic [31:0] t, logic [31:0] f);
    repeat (2) @(posedge clk_i);
    rd(smsr_pkg::ADDR_ACTUAL, a, "actual");
    rd(smsr_pkg::ADDR_TARGET, t, "target");
    rd(smsr_pkg::ADDR_FUNCTION, f, "function");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Reset values, masking, read-only and unmapped places
  task automatic t_regs();
    logic [31:0] e[11] = '{32'h0, 32'h0, 32'h115, 32'h12, 32'h3FF, 32'h0, 32'h0, 32'h0, 32'h0,
                           32'h0, 32'h10000};
    for (int i = 0; i < 11; i++)
      rd(8'(3 + i), e[i], "reset value");
    wr(8'hFE, 32'hFFFF_FFFF);
    rd(8'hFE, 32'h0, "unmapped");
    rd(smsr_pkg::ADDR_FAST_CMD, 32'h0, "fast cmd read");
    wr(smsr_pkg::ADDR_VEL_AVG, 32'h77);
    rd(smsr_pkg::ADDR_VEL_AVG, 32'h0, "velocity average");
    wr(smsr_pkg::ADDR_TORQUE, 32'h555);
    rd(smsr_pkg::ADDR_TORQUE, 32'h155, "torque limit");
    wr(smsr_pkg::ADDR_LOAD, 32'h0002_8000);
    rd(smsr_pkg::ADDR_LOAD, 32'h0002_8000, "load ratio");
    chk("load output", 32'h0002_8000, load);
    $display("test regs done");
  endtask
  // Absolute, relative and both fast commands in turn
  task automatic t_update();
    wr(smsr_pkg::ADDR_NEW_POS, 32'h1000);
    wr(smsr_pkg::ADDR_CONTROL, 32'h40);
    pos3(32'h1000, 32'h1000, 32'h1000);
    wr(smsr_pkg::ADDR_NEW_POS, 32'hFFFF_FFF0);
    wr(smsr_pkg::ADDR_CONTROL, 32'h140);
    pos3(32'hFF0, 32'hFF0, 32'hFF0);
    wr(smsr_pkg::ADDR_NEW_POS, 32'h200);
    wr(smsr_pkg::ADDR_FAST_CMD, smsr_pkg::FAST_CMD_ABSOLUTE);
    pos3(32'h200, 32'h200, 32'h200);
    wr(smsr_pkg::ADDR_FAST_CMD, smsr_pkg::FAST_CMD_RELATIVE);
    pos3(32'h400, 32'h400, 32'h400);
    $display("test update done");
  endtask
  // Host offset while passive, then twenty counts up and, at divider 2, twenty down
  task automatic t_encoder();
    wr(smsr_pkg::ADDR_ACTUAL, 32'h64);
    for (int d = 0; d < 2; d++)
    begin
      if (d == 1)
        wr(smsr_pkg::ADDR_LOOP_DIV, {24'h0, smsr_pkg::LOOP_DIV_DOUBLE});
      down <= d[0];
      @(posedge clk_i);
      run <= 1'b1;
      repeat (80) @(posedge clk_i);
      run <= 1'b0;
      repeat (60) @(posedge clk_i);
      rd(smsr_pkg::ADDR_ACTUAL, d ? 32'h64 : 32'h78, "encoder");
      rd(smsr_pkg::ADDR_VEL_AVG, d ? 32'h0 : 32'h1, "velocity mean");
    end
    rd(smsr_pkg::ADDR_LOOP_DIV, 32'h2, "loop divider");
    $display("test encoder done");
  endtask
  // Zero search end records index and overwrites actual
  task automatic t_zero();
    @(posedge clk_i);
    zturn <= 32'h1234;
    zpos  <= 32'h55;
    zdone <= 1'b1;
    @(posedge clk_i);
    zdone <= 1'b0;
    rd(smsr_pkg::ADDR_ZERO_INDEX, 32'h1234, "zero index");
    rd(smsr_pkg::ADDR_ACTUAL, 32'h55, "zero actual");
    $display("test zero done");
  endtask
  // Position mode drives, other modes leave the axis free
  task automatic t_mode();
    logic [7:0] m[3] = '{smsr_pkg::MODE_POSITION, 8'h01, smsr_pkg::MODE_PASSIVE};
    wr(smsr_pkg::ADDR_TARGET, 32'h155);
    for (int i = 0; i < 3; i++)
    begin
      wr(smsr_pkg::ADDR_MODE, {24'h0, m[i]});
      if (i == 0)
      begin
        // First regulator step, then the next one a divided period later
        for (int k = 0; k < 50 && vcmd == 32'sh0; k++)
          @(posedge clk_i);
        chk("velocity command", 32'h12, vcmd);
        chk("torque command", 32'h12, 32'(tcmd));
        repeat (38) @(posedge clk_i);
        chk("velocity hold", 32'h12, vcmd);
        repeat (2) @(posedge clk_i);
        chk("velocity step", 32'h24, vcmd);
      end
      repeat (3) @(posedge clk_i);
      chk("drive enable", {31'h0, i == 0}, {31'h0, enable});
    end
    $display("test mode done");
  endtask
  ////////////////////////////////////////
  // Hang guard, well above the expected run length
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_update();
    t_encoder();
    t_zero();
    t_mode();
    report_and_stop();
  end
endmodule

// >>> dv/smsr_enc_model.sv
// Encoder model that stands in for the motor shaft.
// Assumes the bench gates it with run_i on the same clock.
module smsr_enc_model (
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic down_i,
  output logic      step_o,
  output logic      dir_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;

  // Two cycles high, two low per count; still when idle
  always_ff @(posedge clk_i)
  begin
    phase <= run_i ? phase + 2'h1 : 2'h0;
  end
  assign step_o = phase[1];
  assign dir_o  = down_i;
endmodule

// >>> dv/smsr_properties.sv
// Port checker for the setpoint register group.
// Assumes a bind to smsr_registers and a single clock.
module smsr_checker #(
  parameter int SAMPLE_CYCLES = 20
) (
  input wire logic               clk_i,
  input wire logic               reset_i,
  input wire logic        [7:0]  addr_i,
  input wire logic        [31:0] wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic        [31:0] rdata_o,
  input wire logic               drive_enable_o,
  input wire logic signed [31:0] velocity_command_o,
  input wire logic signed [10:0] torque_command_o,
  input wire logic        [31:0] load_inertia_ratio_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  // Mode write step; load write carries its value
  sequence s_mode(logic [7:0] m);
    wr_i && addr_i == smsr_pkg::ADDR_MODE && wdata_i[7:0] == m;
  endsequence
  property p_load;
    wr_i && addr_i == smsr_pkg::ADDR_LOAD |=> load_inertia_ratio_o == $past(wdata_i);
  endproperty
  AST_PASSIVE_OFF: assert property (s_mode(smsr_pkg::MODE_PASSIVE) |-> ##2 !drive_enable_o)
    else $error("drive enabled in passive mode");
  AST_POSITION_ON: assert property (s_mode(smsr_pkg::MODE_POSITION) |-> ##2 drive_enable_o)
    else $error("drive not enabled in position mode");
  AST_OTHER_MODE: assert property (s_mode(8'h01) |-> ##2 !drive_enable_o)
    else $error("drive enabled in unsupported mode");
  AST_PASSIVE_ZERO: assert property (!drive_enable_o && $past(!drive_enable_o) |->
    velocity_command_o == 32'sh0 && torque_command_o == 11'sh0)
    else $error("commands not zero while passive");
  AST_TORQUE_CAP: assert property (torque_command_o >= -11'sd1023)
    else $error("torque command beyond limit");
  AST_LOAD_RESET: assert property ($fell(reset_i) |-> load_inertia_ratio_o == 32'h0001_0000)
    else $error("load ratio not unity after reset");
  AST_LOAD_WRITE: assert property (p_load)
    else $error("load ratio output missed a write");
  AST_FAST_READ: assert property (rd_i && addr_i == smsr_pkg::ADDR_FAST_CMD |=> rdata_o == 32'h0)
    else $error("fast command index read not zero");
endmodule

bind smsr_registers smsr_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.clk_i(clk_i),
  .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .drive_enable_o(drive_enable_o), .velocity_command_o(velocity_command_o),
  .torque_command_o(torque_command_o), .load_inertia_ratio_o(load_inertia_ratio_o));

// >>> src/smsr_motion_if.sv
// Carrier between the sample timer and the register core.
// Assumes both ends run on the same clock.
interface smsr_motion_if;
  logic               sample;     // One-cycle pulse per control sample
  logic signed [31:0] delta;      // Encoder counts moved in last sample
  logic signed [31:0] vel_avg;    // Mean of the last sixteen deltas
  logic        [7:0]  loop_div;   // Loop divider from the core

  modport sampler (output sample, output delta, output vel_avg, input loop_div);
  modport core    (input sample, input delta, input vel_avg, output loop_div);
endinterface

// >>> src/smsr_pkg.sv
// Constants for the servo setpoint and feedback register group.
// Assumes a 10 MHz system clock and a register port addressed by register index.
package smsr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices, one 32-bit word each
  localparam logic [7:0] ADDR_MODE       = 8'h02;
  localparam logic [7:0] ADDR_TARGET     = 8'h03;
  localparam logic [7:0] ADDR_NEW_POS    = 8'h04;
  localparam logic [7:0] ADDR_VELOCITY   = 8'h05;
  localparam logic [7:0] ADDR_ACCEL      = 8'h06;
  localparam logic [7:0] ADDR_TORQUE     = 8'h07;
  localparam logic [7:0] ADDR_FUNCTION   = 8'h08;
  localparam logic [7:0] ADDR_ZERO_INDEX = 8'h09;
  localparam logic [7:0] ADDR_ACTUAL     = 8'h0A;
  localparam logic [7:0] ADDR_VEL_AVG    = 8'h0B;
  localparam logic [7:0] ADDR_VEL_INST   = 8'h0C;
  localparam logic [7:0] ADDR_LOAD       = 8'h0D;
  localparam logic [7:0] ADDR_CONTROL    = 8'h24;
  localparam logic [7:0] ADDR_FAST_CMD   = 8'h25;
  localparam logic [7:0] ADDR_LOOP_DIV   = 8'h9D;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [31:0] RESET_POSITION = 32'h0000_0000;
  localparam logic [31:0] RESET_VELOCITY = 32'h0000_0115;
  localparam logic [31:0] RESET_ACCEL    = 32'h0000_0012;
  localparam logic [9:0]  RESET_TORQUE   = 10'h3FF;
  localparam logic [31:0] RESET_LOAD     = 32'h0001_0000;
  localparam logic [7:0]  RESET_MODE     = 8'h00;
  localparam logic [7:0]  RESET_LOOP_DIV = 8'h01;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and codes
  localparam int          CTRL_EXECUTE_BIT  = 6;
  localparam int          CTRL_RELATIVE_BIT = 8;
  localparam logic [31:0] FAST_CMD_ABSOLUTE = 32'h0000_0017;
  localparam logic [31:0] FAST_CMD_RELATIVE = 32'h0000_0018;
  localparam logic [7:0]  MODE_PASSIVE      = 8'h00;
  localparam logic [7:0]  MODE_POSITION     = 8'h02;
  localparam logic [7:0]  LOOP_DIV_DOUBLE   = 8'h02;
  localparam logic [31:0] TORQUE_FULL_SCALE = 32'h0000_03FF;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: control loop sample period
  localparam int SAMPLE_TIME_US = 1300;
  localparam int CLK_FREQ_MHZ   = 10;
  localparam int SAMPLE_CYCLES  = SAMPLE_TIME_US * CLK_FREQ_MHZ;
  localparam int AVG_DEPTH      = 16;
  localparam int AVG_SHIFT      = 4;

endpackage

// >>> src/smsr_registers.sv
// Setpoint and feedback registers of a servo drive, with the combined
// position update and a simple position regulator.
// Assumes a register master on clk_i and encoder pins from the motor.
//
// Decided for this implementation: the strobed register port.

////////////////////////////////////////////////////////////////////////////////
module smsr_registers #(
  parameter int SAMPLE_CYCLES = smsr_pkg::SAMPLE_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic        [7:0]  addr_i,
  input  wire logic        [31:0] wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic             [31:0] rdata_o,
  input  wire logic               enc_step_i,
  input  wire logic               enc_dir_i,
  input  wire logic               zero_done_i,
  input  wire logic        [31:0] zero_single_turn_i,
  input  wire logic        [31:0] zero_position_i,
  output logic                    drive_enable_o,
  output logic signed      [31:0] velocity_command_o,
  output logic signed      [10:0] torque_command_o,
  output logic             [31:0] load_inertia_ratio_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Symmetric saturation to plus or minus a non-negative limit
  function automatic logic signed [31:0] sat32(input logic signed [31:0] x,
                                              input logic signed [31:0] lim);
    logic signed [31:0] r;
    r = x;
    if (x > lim)
      r = lim;
    else if (x < -lim)
      r = -lim;
    return r;
  endfunction

  // Register write strobe for one index
  function automatic logic wr_hit(input logic       we,
                                  input logic [7:0] a,
                                  input logic [7:0] target);
    return we && (a == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Storage

  logic        [7:0]  operating_mode;
  logic signed [31:0] target_position;
  logic signed [31:0] new_position_load;
  logic signed [31:0] velocity_setpoint;
  logic signed [31:0] acceleration_setpoint;
  logic        [9:0]  torque_limit;
  logic signed [31:0] function_position;
  logic        [31:0] zero_index_position;
  logic signed [31:0] actual_position;
  logic        [31:0] load_inertia_ratio;
  logic        [7:0]  output_loop_divider;
  logic               relative_update_select;
  logic               update_pending;

  logic               fast_abs;
  logic               fast_rel;
  logic               ctrl_exec;
  logic               update_req;
  logic               req_relative;
  logic               update_now;
  logic               update_rel;
  logic signed [31:0] delta_term;
  logic signed [31:0] next_actual;
  logic signed [31:0] next_cmd_vel;
  logic signed [31:0] next_torque;
  logic        [31:0] read_value;

  smsr_motion_if motion ();

  ////////////////////////////////////////////////////////////////////////////////
  // Sample timer and velocity measurement

  smsr_sampler #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_sampler (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .enc_step_i (enc_step_i),
    .enc_dir_i  (enc_dir_i),
    .m          (motion)
  );

  assign motion.loop_div = output_loop_divider;

  ////////////////////////////////////////////////////////////////////////////////
  // Combined update request decode

  // Fast command codes
  assign fast_abs = wr_hit(wr_i, addr_i, smsr_pkg::ADDR_FAST_CMD)
                    && (wdata_i == smsr_pkg::FAST_CMD_ABSOLUTE);
  assign fast_rel = wr_hit(wr_i, addr_i, smsr_pkg::ADDR_FAST_CMD)
                    && (wdata_i == smsr_pkg::FAST_CMD_RELATIVE);

  // Control write with the execute bit set
  assign ctrl_exec = wr_hit(wr_i, addr_i, smsr_pkg::ADDR_CONTROL)
                     && wdata_i[smsr_pkg::CTRL_EXECUTE_BIT];

  assign update_req   = ctrl_exec || fast_abs || fast_rel;
  // Selection written with the trigger counts, else the stored one
  assign req_relative = fast_rel ||
                        (ctrl_exec && wdata_i[smsr_pkg::CTRL_RELATIVE_BIT]);

  // Never on a sample cycle, so the loop sees both positions moved or neither
  assign update_now = (update_req || update_pending) && !motion.sample;
  assign update_rel = update_req ? req_relative : relative_update_select;

  // Encoder motion lands only on sample cycles
  assign delta_term = motion.sample ? motion.delta : 32'sh0;

  ////////////////////////////////////////////////////////////////////////////////
  // Control bits: relative select is stored, execute shows a pending update

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      relative_update_select <= 1'b0;
    else if (wr_hit(wr_i, addr_i, smsr_pkg::ADDR_CONTROL))
      relative_update_select <= wdata_i[smsr_pkg::CTRL_RELATIVE_BIT];
    else if (fast_abs || fast_rel)
      relative_update_select <= fast_rel;
  end

  // Request caught on a sample cycle waits one cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      update_pending <= 1'b0;
    else if (update_req && motion.sample)
      update_pending <= 1'b1;
    else if (update_now)
      update_pending <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Actual position: zero search, combined update, host write, encoder

  always_comb
  begin
    next_actual = actual_position + delta_term;
    if (zero_done_i)
      next_actual = zero_position_i;
    else if (update_now)
    begin
      if (update_rel)
        next_actual = actual_position + new_position_load;
      else
        next_actual = new_position_load;
    end
    else if (wr_hit(wr_i, addr_i, smsr_pkg::ADDR_ACTUAL))
      next_actual = wdata_i + delta_term;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      actual_position <= smsr_pkg::RESET_POSITION;
    else
      actual_position <= next_actual;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Target position moves in the same cycle as the actual position

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      target_position <= smsr_pkg::RESET_POSITION;
    else if (update_now)
    begin
      if (update_rel)
        target_position <= target_position + new_position_load;
      else
        target_position <= new_position_load;
    end
    else if (wr_hit(wr_i, addr_i, smsr_pkg::ADDR_TARGET))
      target_position <= wdata_i;
  end

  // Function position follows the same step as the actual position
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      function_position <= smsr_pkg::RESET_POSITION;
    else if (update_now && !zero_done_i)
    begin
      if (update_rel)
        function_position <= function_position + new_position_load;
      else
        function_position <= function_position +
                             (new_position_load - actual_position);
    end
    else if (wr_hit(wr_i, addr_i, smsr_pkg::ADDR_FUNCTION))
      function_position <= wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Zero search capture

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      zero_index_position <= smsr_pkg::RESET_POSITION;
    else if (zero_done_i)
      zero_index_position <= zero_single_turn_i;
    else if (wr_hit(wr_i, addr_i, smsr_pkg::ADDR_ZERO_INDEX))
      zero_index_position <= wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Plain setpoint registers

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      operating_mode        <= smsr_pkg::RESET_MODE;
      new_position_load     <= smsr_pkg::RESET_POSITION;
      velocity_setpoint     <= smsr_pkg::RESET_VELOCITY;
      acceleration_setpoint <= smsr_pkg::RESET_ACCEL;
      torque_limit          <= smsr_pkg::RESET_TORQUE;
      load_inertia_ratio    <= smsr_pkg::RESET_LOAD;
      output_loop_divider   <= smsr_pkg::RESET_LOOP_DIV;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        smsr_pkg::ADDR_MODE:     operating_mode        <= wdata_i[7:0];
        smsr_pkg::ADDR_NEW_POS:  new_position_load     <= wdata_i;
        smsr_pkg::ADDR_VELOCITY: velocity_setpoint     <= wdata_i;
        smsr_pkg::ADDR_ACCEL:    acceleration_setpoint <= wdata_i;
        // Wider values are cut to the 0..1023 range
        smsr_pkg::ADDR_TORQUE:   torque_limit          <= wdata_i[9:0];
        smsr_pkg::ADDR_LOAD:     load_inertia_ratio    <= wdata_i;
        smsr_pkg::ADDR_LOOP_DIV: output_loop_divider   <= wdata_i[7:0];
        default: ;
      endcase
    end
  end

  assign load_inertia_ratio_o = load_inertia_ratio;

  ////////////////////////////////////////////////////////////////////////////////
  // Position regulator, stepped once per sample

  // Velocity toward target, slewed by the acceleration, torque capped
  always_comb
  begin
    next_cmd_vel = sat32(target_position - actual_position,
                         sat32(velocity_setpoint, 32'sh7FFF_FFFF));
    next_cmd_vel = velocity_command_o +
                   sat32(next_cmd_vel - velocity_command_o,
                         acceleration_setpoint);
    next_torque  = sat32(next_cmd_vel - motion.delta,
                         32'(torque_limit));
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      velocity_command_o <= 32'sh0;
      torque_command_o   <= 11'sh0;
      drive_enable_o     <= 1'b0;
    end
    else if (operating_mode != smsr_pkg::MODE_POSITION)
    begin
      // Any mode other than position: nothing driven, axis free to move
      velocity_command_o <= 32'sh0;
      torque_command_o   <= 11'sh0;
      drive_enable_o     <= 1'b0;
    end
    else
    begin
      drive_enable_o <= 1'b1;
      if (motion.sample)
      begin
        velocity_command_o <= next_cmd_vel;
        torque_command_o   <= next_torque[10:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe, zero otherwise

  always_comb
  begin
    read_value = 32'h0000_0000;
    unique case (addr_i)
      smsr_pkg::ADDR_MODE:       read_value = {24'h00_0000, operating_mode};
      smsr_pkg::ADDR_TARGET:     read_value = target_position;
      smsr_pkg::ADDR_NEW_POS:    read_value = new_position_load;
      smsr_pkg::ADDR_VELOCITY:   read_value = velocity_setpoint;
      smsr_pkg::ADDR_ACCEL:      read_value = acceleration_setpoint;
      smsr_pkg::ADDR_TORQUE:     read_value = {22'h00_0000, torque_limit};
      smsr_pkg::ADDR_FUNCTION:   read_value = function_position;
      smsr_pkg::ADDR_ZERO_INDEX: read_value = zero_index_position;
      smsr_pkg::ADDR_ACTUAL:     read_value = actual_position;
      smsr_pkg::ADDR_VEL_AVG:    read_value = motion.vel_avg;
      smsr_pkg::ADDR_VEL_INST:   read_value = motion.delta;
      smsr_pkg::ADDR_LOAD:       read_value = load_inertia_ratio;
      smsr_pkg::ADDR_LOOP_DIV:   read_value = {24'h00_0000, output_loop_divider};
      smsr_pkg::ADDR_CONTROL:
      begin
        read_value[smsr_pkg::CTRL_RELATIVE_BIT] = relative_update_select;
        read_value[smsr_pkg::CTRL_EXECUTE_BIT]  = update_pending;
      end
      default:                   read_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
      rdata_o <= read_value;
    else
      rdata_o <= 32'h0000_0000;
  end

endmodule

// >>> src/smsr_sampler.sv
// Sample timer, encoder step counter and sixteen-sample velocity mean.
// Assumes encoder step and direction arrive as asynchronous pins.
module smsr_sampler #(
  parameter int SAMPLE_CYCLES = smsr_pkg::SAMPLE_CYCLES
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          enc_step_i,
  input  wire logic          enc_dir_i,
  smsr_motion_if.sampler     m
);

  logic        [2:0]  step_sync;
  logic        [1:0]  dir_sync;
  logic        [31:0] period_cnt;
  logic        [31:0] period_last;
  logic signed [31:0] count_acc;
  logic signed [31:0] step_val;
  logic signed [31:0] hist [smsr_pkg::AVG_DEPTH];
  logic        [3:0]  hist_idx;
  logic signed [35:0] hist_sum;
  logic               sample_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Two flops on each pin; third step flop only feeds the edge detect
  always_ff @(posedge clk_i)
  begin
    step_sync <= {step_sync[1:0], enc_step_i};
    dir_sync  <= {dir_sync[0], enc_dir_i};
  end

  // Signed step of this cycle
  always_comb
  begin
    step_val = 32'sh0;
    if (step_sync[1] && !step_sync[2])
      step_val = dir_sync[1] ? -32'sh1 : 32'sh1;
  end

  // Divider 2 doubles the period
  assign period_last = (m.loop_div == smsr_pkg::LOOP_DIV_DOUBLE) ?
                       32'(2 * SAMPLE_CYCLES - 1) : 32'(SAMPLE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Period counter and per-sample step total
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      period_cnt <= 32'h0000_0000;
      count_acc  <= 32'sh0;
      m.delta    <= 32'sh0;
      m.sample   <= 1'b0;
    end
    else if (period_cnt >= period_last)
    begin
      period_cnt <= 32'h0000_0000;
      m.delta    <= count_acc + step_val;
      count_acc  <= 32'sh0;
      m.sample   <= 1'b1;
    end
    else
    begin
      period_cnt <= period_cnt + 32'h0000_0001;
      count_acc  <= count_acc + step_val;
      m.sample   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Running sum over a ring of sixteen deltas, one cycle after the sample
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < smsr_pkg::AVG_DEPTH; i++)
        hist[i] <= 32'sh0;
      hist_idx  <= 4'h0;
      hist_sum  <= 36'sh0;
      sample_d  <= 1'b0;
      m.vel_avg <= 32'sh0;
    end
    else
    begin
      sample_d <= m.sample;
      if (m.sample)
      begin
        hist[hist_idx] <= m.delta;
        hist_idx       <= hist_idx + 4'h1;
        hist_sum       <= hist_sum + 36'(m.delta) - 36'(hist[hist_idx]);
      end
      if (sample_d)
        m.vel_avg <= 32'(hist_sum >>> smsr_pkg::AVG_SHIFT);
    end
  end

endmodule
